// File: rtl/tmr_pkg.sv
package tmr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_PRI_CTRL   = 8'h00; // primary control
    localparam logic [7:0] OFS_PRI_COUNT  = 8'h04; // primary count value
    localparam logic [7:0] OFS_PRI_PERIOD = 8'h08; // primary period
    localparam logic [7:0] OFS_STATUS     = 8'h0C; // sticky events, write one to clear
    localparam logic [7:0] OFS_MASK       = 8'h10; // interrupt mask
    localparam logic [7:0] OFS_SEC_BASE   = 8'h20; // first secondary timer block
    localparam int         SEC_STRIDE_SH  = 4;     // 16 bytes per secondary timer
    // sub-offsets within a secondary block (word index)
    localparam logic [1:0] SUB_CTRL       = 2'h0;
    localparam logic [1:0] SUB_COUNT      = 2'h1;
    localparam logic [1:0] SUB_PERIOD     = 2'h2;
    // control field positions
    localparam int         BIT_ON         = 15;    // timer enable
    localparam int         BIT_WR_DIS     = 12;    // async_write_disable, stored only
    localparam int         BIT_WR_PEND    = 11;    // async_write_pending, reads zero
    localparam int         BIT_GATE       = 7;     // gate_accumulate_enable
    localparam int         BIT_PRE_LO     = 4;     // prescale select, two bits
    localparam int         BIT_ASYNC      = 1;     // count external_count_input edges
    // reset values
    localparam logic [15:0] RST_CTRL      = 16'h0000;
    localparam logic [15:0] RST_COUNT     = 16'h0000;
    localparam logic [15:0] RST_PERIOD    = 16'hFFFF;
    // prescale terminal counts for divide by 1, 8, 64, 256
    localparam logic [7:0] PRE_DIV1       = 8'h00;
    localparam logic [7:0] PRE_DIV8       = 8'h07;
    localparam logic [7:0] PRE_DIV64      = 8'h3F;
    localparam logic [7:0] PRE_DIV256     = 8'hFF;
    // external pulses held after wake in async mode
    localparam logic [2:0] WAKE_HOLD_PULSES = 3'h5;
    // period that defeats the async wrap
    localparam logic [15:0] PERIOD_NO_WRAP = 16'h0001;
    // least spacing between count writes, in aclk cycles
    localparam int         MIN_COUNT_WR_GAP = 4;
    // axi responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
endpackage

// File: rtl/tmr_timer_top.sv
`timescale 1ns/1ps
module tmr_timer_top #(
    parameter int N_SEC = 4 // number of secondary timers
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             external_count_input,
    input  wire logic [N_SEC-1:0] external_timer_input,
    input  wire logic             sleep,
    input  wire logic             debug_halt,
    output logic [N_SEC-1:0]      sec_clk_out,
    output logic                  irq
);
    // whole block state
    typedef struct packed {
        logic [15:0]             p_ctrl;   // primary control
        logic [15:0]             p_cnt;    // primary_count_value
        logic [15:0]             p_per;    // primary period
        logic [7:0]              p_pre;    // prescale counter
        logic                    p_first;  // first external edge still to drop
        logic [2:0]              p_wake;   // pulses left to hold after wake
        logic                    ext_q;    // last external_count_input
        logic                    sleep_q;  // last sleep level
        logic [N_SEC:0]          status;   // sticky events
        logic [N_SEC:0]          mask;     // interrupt mask
        logic [N_SEC-1:0][15:0]  s_ctrl;   // secondary control
        logic [N_SEC-1:0][15:0]  s_cnt;    // secondary_count_value
        logic [N_SEC-1:0][15:0]  s_per;    // secondary period
        logic [N_SEC-1:0][15:0]  s_snap;   // readable copy of secondary count
        logic [N_SEC-1:0]        s_tick;   // internal clock output, high while enabled and not asleep
        logic                    aw_ok;    // write address held
        logic [7:0]              awaddr;
        logic                    w_ok;     // write data held
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic [7:0]              raddr;    // address of the answered read
    } tmr_state_t;

    tmr_state_t r_reg;  // registered state
    tmr_state_t r_next; // next state

    // byte-lane merge for 16-bit registers
    function automatic logic [15:0] tmr_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
        logic [15:0] v;
        v = old;
        if (st[0]) v[7:0] = wd[7:0];
        if (st[1]) v[15:8] = wd[15:8];
        return v;
    endfunction

    // secondary index and hit for an address
    function automatic logic sec_hit(input logic [7:0] a);
        logic [3:0] idx;
        idx = a[7:4] - tmr_pkg::OFS_SEC_BASE[7:4];
        return (a >= tmr_pkg::OFS_SEC_BASE) && (int'(idx) < N_SEC) &&
               (a[3:2] != 2'h3);
    endfunction

    // read multiplexer, unmapped flagged by err
    function automatic logic [32:0] tmr_read(input tmr_state_t s, input logic [7:0] a);
        logic [31:0] d;
        logic        err;
        logic [3:0]  idx;
        d = 32'h0000_0000;
        err = 1'b0;
        idx = a[7:4] - tmr_pkg::OFS_SEC_BASE[7:4];
        if (a == tmr_pkg::OFS_PRI_CTRL) begin
            d[15:0] = s.p_ctrl;
            d[tmr_pkg::BIT_WR_PEND] = 1'b0;
        end else if (a == tmr_pkg::OFS_PRI_COUNT) begin
            d[15:0] = s.p_cnt;
        end else if (a == tmr_pkg::OFS_PRI_PERIOD) begin
            d[15:0] = s.p_per;
        end else if (a == tmr_pkg::OFS_STATUS) begin
            d[N_SEC:0] = s.status;
        end else if (a == tmr_pkg::OFS_MASK) begin
            d[N_SEC:0] = s.mask;
        end else if (sec_hit(a)) begin
            unique case (a[3:2])
                tmr_pkg::SUB_CTRL:  d[15:0] = s.s_ctrl[idx];
                tmr_pkg::SUB_COUNT: d[15:0] = s.s_snap[idx];
                default:            d[15:0] = s.s_per[idx];
            endcase
        end else begin
            err = 1'b1;
        end
        return {err, d};
    endfunction

    // all next-state logic
    always_comb begin
        logic            ext_rise;
        logic            src;
        logic            tick;
        logic            amode;
        logic            wake;
        logic            sleep_rise;
        logic            wr_do;
        logic [7:0]      plim;
        logic [3:0]      widx;
        logic [32:0]     rd;
        logic [N_SEC:0]  ev;
        logic [N_SEC:0]  clr;
        ext_rise = external_count_input && !r_reg.ext_q;
        amode = r_reg.p_ctrl[tmr_pkg::BIT_ASYNC];
        wake = r_reg.sleep_q && !sleep;
        sleep_rise = sleep && !r_reg.sleep_q;
        wr_do = r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid;
        plim = tmr_pkg::PRE_DIV1;
        widx = r_reg.awaddr[7:4] - tmr_pkg::OFS_SEC_BASE[7:4];
        rd = tmr_read(r_reg, s_axi_araddr);
        ev = '0;
        clr = '0;
        tick = 1'b0;
        src = 1'b0;
        r_next = r_reg;
        r_next.ext_q = external_count_input;
        r_next.sleep_q = sleep;

        // primary count source: edges, gated level or bus clock
        if (amode) begin
            src = ext_rise;
        end else if (r_reg.p_ctrl[tmr_pkg::BIT_GATE]) begin
            src = external_count_input && !sleep;
        end else begin
            src = !sleep;
        end
        // arm the first-edge loss while stopped
        if (!r_reg.p_ctrl[tmr_pkg::BIT_ON]) begin
            r_next.p_first = 1'b1;
        end else if (amode && ext_rise && r_reg.p_first) begin
            r_next.p_first = 1'b0;
            src = 1'b0;
        end
        // hold count after wake in async mode
        if (wake && amode) begin
            r_next.p_wake = tmr_pkg::WAKE_HOLD_PULSES;
        end else if (r_reg.p_wake != 3'h0 && ext_rise) begin
            r_next.p_wake = r_reg.p_wake - 3'h1;
            src = 1'b0;
        end
        // prescaler
        unique case (r_reg.p_ctrl[tmr_pkg::BIT_PRE_LO +: 2])
            2'h0: plim = tmr_pkg::PRE_DIV1;
            2'h1: plim = tmr_pkg::PRE_DIV8;
            2'h2: plim = tmr_pkg::PRE_DIV64;
            2'h3: plim = tmr_pkg::PRE_DIV256;
        endcase
        if (r_reg.p_ctrl[tmr_pkg::BIT_ON] && src) begin
            if (r_reg.p_pre >= plim) begin
                r_next.p_pre = 8'h00;
                tick = 1'b1;
            end else begin
                r_next.p_pre = r_reg.p_pre + 8'h01;
            end
        end
        // primary compare and wrap
        if (tick) begin
            if (r_reg.p_cnt == r_reg.p_per &&
                !(amode && r_reg.p_per == tmr_pkg::PERIOD_NO_WRAP)) begin
                r_next.p_cnt = 16'h0000;
                ev[0] = 1'b1;
            end else begin
                r_next.p_cnt = r_reg.p_cnt + 16'h0001;
            end
        end

        // secondary timers, stopped in sleep
        for (int i = 0; i < N_SEC; i++) begin
            r_next.s_tick[i] = r_reg.s_ctrl[i][tmr_pkg::BIT_ON] && !sleep;
            if (r_reg.s_ctrl[i][tmr_pkg::BIT_ON] && !r_reg.sleep_q &&
                (!r_reg.s_ctrl[i][tmr_pkg::BIT_GATE] || external_timer_input[i])) begin
                if (r_reg.s_cnt[i] == r_reg.s_per[i]) begin
                    r_next.s_cnt[i] = 16'h0000;
                    ev[i+1] = !sleep_rise;
                end else begin
                    r_next.s_cnt[i] = r_reg.s_cnt[i] + 16'h0001;
                end
            end
        end

        // write channel capture
        if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_ok = 1'b1;
            r_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_ok = 1'b1;
            r_next.wdata = s_axi_wdata;
            r_next.wstrb = s_axi_wstrb;
        end
        // register write, software value wins over counting
        if (wr_do) begin
            r_next.aw_ok = 1'b0;
            r_next.w_ok = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = tmr_pkg::RESP_OKAY;
            if (r_reg.awaddr == tmr_pkg::OFS_PRI_CTRL) begin
                r_next.p_ctrl = tmr_merge(r_reg.p_ctrl, r_reg.wdata, r_reg.wstrb);
                r_next.p_ctrl[tmr_pkg::BIT_WR_PEND] = 1'b0;
            end else if (r_reg.awaddr == tmr_pkg::OFS_PRI_COUNT) begin
                r_next.p_cnt = tmr_merge(r_reg.p_cnt, r_reg.wdata, r_reg.wstrb);
            end else if (r_reg.awaddr == tmr_pkg::OFS_PRI_PERIOD) begin
                r_next.p_per = tmr_merge(r_reg.p_per, r_reg.wdata, r_reg.wstrb);
            end else if (r_reg.awaddr == tmr_pkg::OFS_STATUS) begin
                if (r_reg.wstrb[0]) clr = r_reg.wdata[N_SEC:0];
            end else if (r_reg.awaddr == tmr_pkg::OFS_MASK) begin
                if (r_reg.wstrb[0]) r_next.mask = r_reg.wdata[N_SEC:0];
            end else if (sec_hit(r_reg.awaddr)) begin
                unique case (r_reg.awaddr[3:2])
                    tmr_pkg::SUB_CTRL: r_next.s_ctrl[widx] =
                        tmr_merge(r_reg.s_ctrl[widx], r_reg.wdata, r_reg.wstrb);
                    tmr_pkg::SUB_COUNT: r_next.s_cnt[widx] =
                        tmr_merge(r_reg.s_cnt[widx], r_reg.wdata, r_reg.wstrb);
                    default: r_next.s_per[widx] =
                        tmr_merge(r_reg.s_per[widx], r_reg.wdata, r_reg.wstrb);
                endcase
            end else begin
                r_next.bresp = tmr_pkg::RESP_SLVERR;
            end
        end
        if (r_reg.bvalid && s_axi_bready) r_next.bvalid = 1'b0;

        // sticky events, a new event beats the clear
        r_next.status = (r_reg.status & ~clr) | ev;

        // count copy seen by reads, frozen while halted
        if (!debug_halt) r_next.s_snap = r_next.s_cnt;

        // read channel
        if (r_reg.rvalid && s_axi_rready) r_next.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            r_next.rvalid = 1'b1;
            r_next.rdata = rd[31:0];
            r_next.rresp = rd[32] ? tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
            r_next.raddr = s_axi_araddr;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.p_ctrl <= tmr_pkg::RST_CTRL;
            r_reg.p_cnt <= tmr_pkg::RST_COUNT;
            r_reg.p_per <= tmr_pkg::RST_PERIOD;
            r_reg.p_first <= 1'b1;
            for (int i = 0; i < N_SEC; i++) begin
                r_reg.s_ctrl[i] <= tmr_pkg::RST_CTRL;
                r_reg.s_cnt[i] <= tmr_pkg::RST_COUNT;
                r_reg.s_per[i] <= tmr_pkg::RST_PERIOD;
            end
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs
    assign s_axi_awready = !r_reg.aw_ok && !r_reg.bvalid;
    assign s_axi_wready  = !r_reg.w_ok && !r_reg.bvalid;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_arready = !r_reg.rvalid;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rdata   = r_reg.rdata;
    assign s_axi_rresp   = r_reg.rresp;
    assign sec_clk_out   = r_reg.s_tick;
    assign irq           = |(r_reg.status & r_reg.mask);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // async external edge with no write address held, seen by helper
    logic a_amode;
    assign a_amode = r_reg.p_ctrl[tmr_pkg::BIT_ASYNC];
    sequence s_edge_held;
        a_amode && external_count_input && !r_reg.ext_q && !r_reg.aw_ok;
    endsequence

    a_match_wrap: assert property (
        r_reg.p_ctrl[tmr_pkg::BIT_ON] && !a_amode && !r_reg.p_ctrl[tmr_pkg::BIT_GATE]
        && r_reg.p_ctrl[5:4] == 2'h0 && !sleep && !r_reg.aw_ok
        && r_reg.p_cnt == r_reg.p_per |=> r_reg.p_cnt == 16'h0000 && r_reg.status[0])
        else $error("primary did not wrap on period match");
    a_wake_hold: assert property (
        (r_reg.p_wake != 3'h0) and s_edge_held |=> $stable(r_reg.p_cnt))
        else $error("count moved during wake hold");
    a_wake_arm: assert property (
        a_amode && r_reg.sleep_q && !sleep |=> r_reg.p_wake == 3'h5)
        else $error("wake hold not armed to five");
    a_first_drop: assert property (
        (r_reg.p_ctrl[tmr_pkg::BIT_ON] && r_reg.p_first) and s_edge_held
        |=> $stable(r_reg.p_cnt) && !r_reg.p_first)
        else $error("first external edge was counted");
    a_no_wrap_one: assert property (
        (r_reg.p_ctrl[tmr_pkg::BIT_ON] && r_reg.p_per == 16'h0001
        && r_reg.p_cnt == 16'h0001 && r_reg.p_ctrl[5:4] == 2'h0 && r_reg.p_wake == 3'h0
        && !r_reg.p_first) and s_edge_held |=> r_reg.p_cnt == 16'h0002)
        else $error("async period one wrapped");
    a_pend_zero: assert property (
        r_reg.rvalid && r_reg.raddr == tmr_pkg::OFS_PRI_CTRL |-> !r_reg.rdata[11])
        else $error("write pending reads set");
    a_halt_frozen: assert property (
        debug_halt [*2] |-> $stable(r_reg.s_snap))
        else $error("secondary copy moved during halt");
    a_clk_ungated: assert property (
        r_reg.s_ctrl[0][tmr_pkg::BIT_ON] && external_timer_input[0] && !sleep
        && !r_reg.aw_ok |=> sec_clk_out[0])
        else $error("secondary clock output gated");
    a_sleep_drop: assert property (
        sleep && !r_reg.sleep_q && !r_reg.status[1] && !r_reg.aw_ok
        |=> !r_reg.status[1])
        else $error("match event kept at sleep entry");
endmodule

// File: tb/tmr_tb.sv
`timescale 1ns/1ps
module tb;
    logic        aclk;                  // bus clock
    logic        aresetn;               // synchronous reset, active low
    logic [7:0]  awaddr;                // write address channel
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;                 // write data channel
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;                 // write response channel
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;                // read address channel
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;                 // read data channel
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        ext_cnt;               // primary external count edges
    logic [3:0]  ext_tmr;               // secondary gate levels
    logic        sleep;                 // device asleep
    logic        debug_halt;            // debugger halt
    logic [3:0]  sec_clk_out;           // secondary clock outputs
    logic        irq;                   // interrupt level
    int          failures;              // mismatches seen
    int          compares;              // comparisons made
    logic [31:0] d0;                    // scratch read values
    logic [31:0] d1;

    // device under test
    tmr_timer_top #(.N_SEC(4)) tmr_timer_top_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .external_count_input(ext_cnt), .external_timer_input(ext_tmr),
        .sleep(sleep), .debug_halt(debug_halt), .sec_clk_out(sec_clk_out), .irq(irq));

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    // one read, response code checked
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // read and compare against an expected word
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v, tmr_pkg::RESP_OKAY);
        chk(what, exp, v);
    endtask

    // rising edges on the external count input
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge aclk);
            ext_cnt <= 1'b1;
            repeat (2) @(posedge aclk);
            ext_cnt <= 1'b0;
            @(posedge aclk);
        end
        repeat (3) @(posedge aclk);
    endtask

    // reset values, unmapped place, inert write-control bits
    task automatic t_reset();
        chk("irq idle", 32'h0, {31'h0, irq});
        chk("sec clk idle", 32'h0, {28'h0, sec_clk_out});
        rc("pri ctrl", tmr_pkg::OFS_PRI_CTRL, 32'h0);
        rc("pri count", tmr_pkg::OFS_PRI_COUNT, 32'h0);
        rc("pri period", tmr_pkg::OFS_PRI_PERIOD, 32'h0000FFFF);
        rc("sec period", tmr_pkg::OFS_SEC_BASE + 8'h08, 32'h0000FFFF);
        rc("status", tmr_pkg::OFS_STATUS, 32'h0);
        rd(8'h1C, d0, tmr_pkg::RESP_SLVERR);
        chk("unmapped data", 32'h0, d0);
        wr(8'h1C, 32'hFFFFFFFF, tmr_pkg::RESP_SLVERR);
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h00001800, tmr_pkg::RESP_OKAY);
        rc("pend reads zero", tmr_pkg::OFS_PRI_CTRL, 32'h00001000);
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h0, tmr_pkg::RESP_OKAY);
        $display("test reset done");
    endtask

    // synchronous counting, wrap flag, mask and clear
    task automatic t_sync();
        wr(tmr_pkg::OFS_PRI_PERIOD, 32'h3, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h00009000, tmr_pkg::RESP_OKAY);
        repeat (20) @(posedge aclk);
        rc("wrap event", tmr_pkg::OFS_STATUS, 32'h1);
        rd(tmr_pkg::OFS_PRI_COUNT, d0, tmr_pkg::RESP_OKAY);
        chk("count within period", 32'h1, {31'h0, d0 <= 32'h3});
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(tmr_pkg::OFS_MASK, 32'h1, tmr_pkg::RESP_OKAY);
        @(posedge aclk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h0, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_STATUS, 32'h1, tmr_pkg::RESP_OKAY);
        rc("status cleared", tmr_pkg::OFS_STATUS, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(tmr_pkg::OFS_PRI_COUNT, 32'h1234, tmr_pkg::RESP_OKAY);
        rc("count written", tmr_pkg::OFS_PRI_COUNT, 32'h1234);
        // gated mode with the prescaler left at divide by one
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h00008080, tmr_pkg::RESP_OKAY);
        repeat (5) @(posedge aclk);
        rc("gate closed", tmr_pkg::OFS_PRI_COUNT, 32'h1234);
        ext_cnt <= 1'b1;
        repeat (5) @(posedge aclk);
        ext_cnt <= 1'b0;
        rd(tmr_pkg::OFS_PRI_COUNT, d0, tmr_pkg::RESP_OKAY);
        chk("gate open counts", 32'h1, {31'h0, d0 > 32'h1234});
        // divide by 256: no tick within a few dozen cycles
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h00008030, tmr_pkg::RESP_OKAY);
        repeat (20) @(posedge aclk);
        rc("prescaled holds", tmr_pkg::OFS_PRI_COUNT, d0);
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h0, tmr_pkg::RESP_OKAY);
        $display("test sync done");
    endtask

    // external counting: lost first edge, wake hold, no wrap at one
    task automatic t_async();
        repeat (tmr_pkg::MIN_COUNT_WR_GAP) @(posedge aclk);
        wr(tmr_pkg::OFS_PRI_COUNT, 32'h0, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_PRI_PERIOD, 32'h64, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h00008002, tmr_pkg::RESP_OKAY);
        pulse(4);
        rc("first edge lost", tmr_pkg::OFS_PRI_COUNT, 32'h3);
        sleep <= 1'b1;
        pulse(2);
        rc("counts asleep", tmr_pkg::OFS_PRI_COUNT, 32'h5);
        sleep <= 1'b0;
        pulse(5);
        rc("wake hold", tmr_pkg::OFS_PRI_COUNT, 32'h5);
        pulse(2);
        rc("after hold", tmr_pkg::OFS_PRI_COUNT, 32'h7);
        wr(tmr_pkg::OFS_PRI_PERIOD, {16'h0, tmr_pkg::PERIOD_NO_WRAP}, tmr_pkg::RESP_OKAY);
        repeat (tmr_pkg::MIN_COUNT_WR_GAP) @(posedge aclk);
        wr(tmr_pkg::OFS_PRI_COUNT, 32'h0, tmr_pkg::RESP_OKAY);
        pulse(3);
        rc("no wrap at one", tmr_pkg::OFS_PRI_COUNT, 32'h3);
        rc("no wrap event", tmr_pkg::OFS_STATUS, 32'h0);
        wr(tmr_pkg::OFS_PRI_CTRL, 32'h0, tmr_pkg::RESP_OKAY);
        $display("test async done");
    endtask

    // secondary: event, clock output, halted read
    task automatic t_sec();
        ext_tmr <= 4'h1;
        wr(tmr_pkg::OFS_SEC_BASE + 8'h08, 32'h3, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_SEC_BASE, 32'h00008000, tmr_pkg::RESP_OKAY);
        repeat (20) @(posedge aclk);
        chk("sec clk ungated", 32'h1, {28'h0, sec_clk_out});
        rc("sec event", tmr_pkg::OFS_STATUS, 32'h2);
        wr(tmr_pkg::OFS_SEC_BASE + 8'h08, 32'hFFFF, tmr_pkg::RESP_OKAY);
        debug_halt <= 1'b1;
        rd(tmr_pkg::OFS_SEC_BASE + 8'h04, d0, tmr_pkg::RESP_OKAY);
        repeat (10) @(posedge aclk);
        rd(tmr_pkg::OFS_SEC_BASE + 8'h04, d1, tmr_pkg::RESP_OKAY);
        chk("halted read", d0, d1);
        debug_halt <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(tmr_pkg::OFS_SEC_BASE + 8'h04, d1, tmr_pkg::RESP_OKAY);
        chk("read resumes", 32'h1, {31'h0, d1 !== d0});
        sleep <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("sec clk asleep", 32'h0, {28'h0, sec_clk_out});
        sleep   <= 1'b0;
        ext_tmr <= 4'h0;
        wr(tmr_pkg::OFS_SEC_BASE, 32'h0, tmr_pkg::RESP_OKAY);
        // match lands in the cycle that sleep rises
        wr(tmr_pkg::OFS_STATUS, 32'h2, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_SEC_BASE + 8'h04, 32'h0, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_SEC_BASE + 8'h08, 32'h1, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_SEC_BASE, 32'h00008000, tmr_pkg::RESP_OKAY);
        sleep <= 1'b1;
        repeat (5) @(posedge aclk);
        rc("match lost at sleep", tmr_pkg::OFS_STATUS, 32'h0);
        sleep <= 1'b0;
        repeat (5) @(posedge aclk);
        rc("match after wake", tmr_pkg::OFS_STATUS, 32'h2);
        wr(tmr_pkg::OFS_SEC_BASE, 32'h0, tmr_pkg::RESP_OKAY);
        wr(tmr_pkg::OFS_STATUS, 32'h2, tmr_pkg::RESP_OKAY);
        $display("test secondary done");
    endtask

    // counts, verdict and end of run
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        give_verdict();
    end

    // main sequence
    initial begin
        failures   = 0;
        compares   = 0;
        aresetn    = 1'b0;
        awaddr     = 8'h00;
        awvalid    = 1'b0;
        wdata      = 32'h0;
        wstrb      = 4'h0;
        wvalid     = 1'b0;
        bready     = 1'b0;
        araddr     = 8'h00;
        arvalid    = 1'b0;
        rready     = 1'b0;
        ext_cnt    = 1'b0;
        ext_tmr    = 4'h0;
        sleep      = 1'b0;
        debug_halt = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_sync();
        t_async();
        t_sec();
        give_verdict();
    end
endmodule
